// file: design/ccf_defines.svh
/*
 * ccf_defines.svh: offsets, field positions and reset values of the
 * controller capability register bank.
 * assumes: included by its bare name by the package and the bank module.
 */
`ifndef CCF_DEFINES_SVH
`define CCF_DEFINES_SVH

// byte addresses of the capability words on the register bus
`define CCF_OFS_EVT_SUPPORT    12'h05c
`define CCF_OFS_CTRL_ATTR      12'h060
`define CCF_OFS_ADMIN_CMDS     12'h100
// limit bytes 0x102 and 0x103 share the aligned word at 0x100
`define CCF_OFS_LIMIT_BYTE_AB  12'h102
`define CCF_OFS_LIMIT_BYTE_AE  12'h103
// own registers: event enables, event status, clear, interrupt mask
`define CCF_OFS_EVT_ENABLE     12'h200
`define CCF_OFS_IRQ_STATUS     12'h204
`define CCF_OFS_IRQ_CLEAR      12'h208
`define CCF_OFS_IRQ_ENABLE     12'h20c

// event support field bits
`define CCF_EVT_FW_ACT_BIT     9
`define CCF_EVT_NS_ATTR_BIT    8
// controller attribute bit
`define CCF_ATTR_HOSTID128_BIT 0
// admin command support bits
`define CCF_ADM_NS_MGMT_BIT    3
`define CCF_ADM_FW_BIT         2
`define CCF_ADM_FORMAT_BIT     1
`define CCF_ADM_SECURITY_BIT   0
// byte positions of the limits in the admin word
`define CCF_ABORT_LIM_LSB      16
`define CCF_EVTREQ_LIM_LSB     24

// capability values (zero-based limits: 8'h03 means four outstanding)
`define CCF_CAP_FW_ACT         1'b1
`define CCF_CAP_NS_ATTR        1'b1
`define CCF_CAP_HOSTID128      1'b0
`define CCF_CAP_NS_MGMT        1'b1
`define CCF_CAP_FW             1'b1
`define CCF_CAP_FORMAT         1'b1
`define CCF_CAP_SECURITY       1'b0
`define CCF_CAP_ABORT_LIM      8'h03
`define CCF_CAP_EVTREQ_LIM     8'h03

`define CCF_ZERO32             32'h0000_0000
`define CCF_RESP_OKAY          2'b00
`define CCF_RESP_SLVERR        2'b10
`define CCF_NUM_EVT            2

`endif

// file: design/ccf_pkg.sv
/*
 * ccf_pkg: types of the controller capability register bank.
 * assumes: ccf_defines.svh on the include path.
 */
`default_nettype none

package ccf_pkg;
`include "ccf_defines.svh"

    typedef logic [`CCF_NUM_EVT-1:0] ccf_evt_t;

    typedef enum logic [1:0] {
        CCF_RD_IDLE = 2'b00,
        CCF_RD_RESP = 2'b01
    } ccf_rd_state_t;

    typedef enum logic [1:0] {
        CCF_WR_IDLE = 2'b00,
        CCF_WR_RESP = 2'b01
    } ccf_wr_state_t;

endpackage : ccf_pkg

`default_nettype wire

// file: design/ccf_bank.sv
/*
 * ccf_bank: read-only controller capability words behind an AXI4-Lite
 * slave, plus gating of optional asynchronous event notices.
 * assumes: one clock clk_sys, synchronous active-low nrst; event pulses
 * come from logic on the same clock.
 */
`include "ccf_defines.svh"
`default_nettype none

module ccf_bank
    import ccf_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // axi4-lite write address
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // event sources: bit 1 firmware activation, bit 0 namespace attribute
    input wire logic [1:0] evt_raise,
    // event notices towards the command path
    output logic [1:0] evt_notice,
    // interrupt
    output logic irq
);

    // constant capability words
    wire logic [31:0] evt_support_word;
    wire logic [31:0] ctrl_attr_word;
    wire logic [31:0] admin_word;

    assign evt_support_word = {22'h00_0000,
                               `CCF_CAP_FW_ACT,
                               `CCF_CAP_NS_ATTR,
                               8'h00};
    assign ctrl_attr_word = {31'h0000_0000,
                             `CCF_CAP_HOSTID128};
    // limits set to 3 give four outstanding commands each
    assign admin_word = {`CCF_CAP_EVTREQ_LIM,
                         `CCF_CAP_ABORT_LIM,
                         12'h000,
                         `CCF_CAP_NS_MGMT,
                         `CCF_CAP_FW,
                         `CCF_CAP_FORMAT,
                         `CCF_CAP_SECURITY};

    // event support mask in the same layout as the status bits
    wire ccf_evt_t evt_capable;
    assign evt_capable = {evt_support_word[`CCF_EVT_FW_ACT_BIT],
                          evt_support_word[`CCF_EVT_NS_ATTR_BIT]};

    // software state
    ccf_evt_t evt_enable_r, evt_enable_nxt;
    ccf_evt_t irq_status_r, irq_status_nxt;
    ccf_evt_t irq_enable_r, irq_enable_nxt;
    ccf_evt_t notice_r, notice_nxt;

    // write channel
    ccf_wr_state_t wr_state_r, wr_state_nxt;
    logic aw_held_r, aw_held_nxt;
    logic w_held_r, w_held_nxt;
    logic [11:0] awaddr_r, awaddr_nxt;
    logic [31:0] wdata_r, wdata_nxt;
    logic [3:0] wstrb_r, wstrb_nxt;
    logic [1:0] bresp_r, bresp_nxt;

    wire logic aw_take;
    wire logic w_take;
    wire logic wr_go;
    wire logic [11:0] wr_word_addr;
    wire logic wr_low_lane;
    wire logic wr_hit_enable;
    wire logic wr_hit_clear;
    wire logic wr_hit_irq_en;
    wire logic wr_hit_ro;
    wire logic wr_ok;

    assign s_axi_awready = (wr_state_r == CCF_WR_IDLE) && !aw_held_r;
    assign s_axi_wready = (wr_state_r == CCF_WR_IDLE) && !w_held_r;
    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take = s_axi_wvalid && s_axi_wready;
    assign wr_go = (wr_state_r == CCF_WR_IDLE) && aw_held_r && w_held_r;
    assign wr_word_addr = {awaddr_r[11:2], 2'b00};
    assign wr_low_lane = wstrb_r[0];
    assign wr_hit_enable = wr_word_addr == `CCF_OFS_EVT_ENABLE;
    assign wr_hit_clear = wr_word_addr == `CCF_OFS_IRQ_CLEAR;
    assign wr_hit_irq_en = wr_word_addr == `CCF_OFS_IRQ_ENABLE;
    // capability and status words accept and ignore writes
    assign wr_hit_ro = (wr_word_addr == `CCF_OFS_EVT_SUPPORT)
                    || (wr_word_addr == `CCF_OFS_CTRL_ATTR)
                    || (wr_word_addr == `CCF_OFS_ADMIN_CMDS)
                    || (wr_word_addr == `CCF_OFS_IRQ_STATUS);
    assign wr_ok = wr_hit_enable || wr_hit_clear || wr_hit_irq_en || wr_hit_ro;

    always_comb
    begin
        wr_state_nxt = wr_state_r;
        aw_held_nxt = aw_held_r;
        w_held_nxt = w_held_r;
        awaddr_nxt = awaddr_r;
        wdata_nxt = wdata_r;
        wstrb_nxt = wstrb_r;
        bresp_nxt = bresp_r;
        case (wr_state_r)
            CCF_WR_IDLE:
            begin
                if (aw_take)
                begin
                    aw_held_nxt = 1'b1;
                    awaddr_nxt = s_axi_awaddr;
                end
                if (w_take)
                begin
                    w_held_nxt = 1'b1;
                    wdata_nxt = s_axi_wdata;
                    wstrb_nxt = s_axi_wstrb;
                end
                if (wr_go)
                begin
                    wr_state_nxt = CCF_WR_RESP;
                    aw_held_nxt = 1'b0;
                    w_held_nxt = 1'b0;
                    bresp_nxt = wr_ok ? `CCF_RESP_OKAY : `CCF_RESP_SLVERR;
                end
            end
            CCF_WR_RESP:
            begin
                if (s_axi_bready)
                begin
                    wr_state_nxt = CCF_WR_IDLE;
                end
            end
            default:
            begin
                wr_state_nxt = CCF_WR_IDLE;
            end
        endcase
    end

    assign s_axi_bvalid = wr_state_r == CCF_WR_RESP;
    assign s_axi_bresp = bresp_r;

    // register updates; a new event wins over a clear in the same cycle
    wire ccf_evt_t wr_bits;
    wire ccf_evt_t evt_set;
    assign wr_bits = wdata_r[`CCF_NUM_EVT-1:0];
    // only supported and host-enabled events may be noticed
    assign evt_set = evt_raise & evt_capable & evt_enable_r;

    always_comb
    begin
        evt_enable_nxt = evt_enable_r;
        irq_enable_nxt = irq_enable_r;
        irq_status_nxt = irq_status_r;
        if (wr_go && wr_low_lane && wr_hit_enable)
        begin
            evt_enable_nxt = wr_bits & evt_capable;
        end
        if (wr_go && wr_low_lane && wr_hit_irq_en)
        begin
            irq_enable_nxt = wr_bits;
        end
        if (wr_go && wr_low_lane && wr_hit_clear)
        begin
            irq_status_nxt = irq_status_r & ~wr_bits;
        end
        irq_status_nxt = irq_status_nxt | evt_set;
        notice_nxt = evt_set;
    end

    // read channel
    ccf_rd_state_t rd_state_r, rd_state_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [1:0] rresp_r, rresp_nxt;
    wire logic ar_take;
    wire logic [11:0] rd_word_addr;
    wire logic rd_hit_evt;
    wire logic rd_hit_attr;
    wire logic rd_hit_admin;
    wire logic rd_hit_enable;
    wire logic rd_hit_status;
    wire logic rd_hit_irq_en;
    wire logic rd_hit_clear;
    wire logic rd_ok;
    wire logic [31:0] rd_word;

    assign s_axi_arready = rd_state_r == CCF_RD_IDLE;
    assign ar_take = s_axi_arvalid && s_axi_arready;
    assign rd_word_addr = {s_axi_araddr[11:2], 2'b00};
    assign rd_hit_evt = rd_word_addr == `CCF_OFS_EVT_SUPPORT;
    assign rd_hit_attr = rd_word_addr == `CCF_OFS_CTRL_ATTR;
    assign rd_hit_admin = rd_word_addr == `CCF_OFS_ADMIN_CMDS;
    assign rd_hit_enable = rd_word_addr == `CCF_OFS_EVT_ENABLE;
    assign rd_hit_status = rd_word_addr == `CCF_OFS_IRQ_STATUS;
    assign rd_hit_irq_en = rd_word_addr == `CCF_OFS_IRQ_ENABLE;
    assign rd_hit_clear = rd_word_addr == `CCF_OFS_IRQ_CLEAR;
    assign rd_ok = rd_hit_evt || rd_hit_attr || rd_hit_admin || rd_hit_enable
                || rd_hit_status || rd_hit_irq_en || rd_hit_clear;
    // clear register is write-only and reads zero
    assign rd_word = rd_hit_evt ? evt_support_word
                   : rd_hit_attr ? ctrl_attr_word
                   : rd_hit_admin ? admin_word
                   : rd_hit_enable ? {30'h0000_0000, evt_enable_r}
                   : rd_hit_status ? {30'h0000_0000, irq_status_r}
                   : rd_hit_irq_en ? {30'h0000_0000, irq_enable_r}
                   : `CCF_ZERO32;

    always_comb
    begin
        rd_state_nxt = rd_state_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        case (rd_state_r)
            CCF_RD_IDLE:
            begin
                if (ar_take)
                begin
                    rd_state_nxt = CCF_RD_RESP;
                    rdata_nxt = rd_word;
                    rresp_nxt = rd_ok ? `CCF_RESP_OKAY : `CCF_RESP_SLVERR;
                end
            end
            CCF_RD_RESP:
            begin
                if (s_axi_rready)
                begin
                    rd_state_nxt = CCF_RD_IDLE;
                end
            end
            default:
            begin
                rd_state_nxt = CCF_RD_IDLE;
            end
        endcase
    end

    assign s_axi_rvalid = rd_state_r == CCF_RD_RESP;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign evt_notice = notice_r;
    assign irq = |(irq_status_r & irq_enable_r);

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            wr_state_r <= CCF_WR_IDLE;
            rd_state_r <= CCF_RD_IDLE;
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= 12'h000;
            wdata_r <= `CCF_ZERO32;
            wstrb_r <= 4'h0;
            bresp_r <= `CCF_RESP_OKAY;
            rdata_r <= `CCF_ZERO32;
            rresp_r <= `CCF_RESP_OKAY;
            evt_enable_r <= '0;
            irq_status_r <= '0;
            irq_enable_r <= '0;
            notice_r <= '0;
        end
        else
        begin
            wr_state_r <= wr_state_nxt;
            rd_state_r <= rd_state_nxt;
            aw_held_r <= aw_held_nxt;
            w_held_r <= w_held_nxt;
            awaddr_r <= awaddr_nxt;
            wdata_r <= wdata_nxt;
            wstrb_r <= wstrb_nxt;
            bresp_r <= bresp_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
            evt_enable_r <= evt_enable_nxt;
            irq_status_r <= irq_status_nxt;
            irq_enable_r <= irq_enable_nxt;
            notice_r <= notice_nxt;
        end
    end

endmodule : ccf_bank

`default_nettype wire

// file: dv/ccf_bank_asserts.sv
/*
 * ccf_bank_asserts: port checks of the capability bank.
 * assumes: bound to ccf_bank below; ccf_defines.svh on the include path.
 */
`include "ccf_defines.svh"
`default_nettype none

module ccf_bank_asserts (
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // read channels
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // events
    input wire logic [1:0] evt_raise,
    input wire logic [1:0] evt_notice,
    input wire logic irq
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    wire logic ar_go = s_axi_arvalid && s_axi_arready;

    // a word read answers on the next cycle with the masked value
    property rd_p(logic [9:0] w, logic [31:0] m, logic [31:0] v);
        ar_go && s_axi_araddr[11:2] == w |=> s_axi_rvalid && (s_axi_rdata & m) == v;
    endproperty

    notice_gate_a: assert property (|evt_notice |-> (evt_notice & ~$past(evt_raise)) == 2'b00)
        else $error("event notice without a raise");
    event_word_a: assert property (rd_p(10'h017, 32'hffff_ffff,
        {22'h00_0000, `CCF_CAP_FW_ACT, `CCF_CAP_NS_ATTR, 8'h00}))
        else $error("event support word wrong");
    attr_word_a: assert property (rd_p(10'h018, 32'hffff_ffff,
        {31'h0000_0000, `CCF_CAP_HOSTID128}))
        else $error("attribute word wrong");
    admin_bits_a: assert property (
        rd_p(10'h040, 32'h0000_ffff, {28'h000_0000, `CCF_CAP_NS_MGMT,
        `CCF_CAP_FW, `CCF_CAP_FORMAT, `CCF_CAP_SECURITY}))
        else $error("admin command bits wrong");
    abort_lim_a: assert property (rd_p(10'h040, 32'h00ff_0000,
        {8'h00, `CCF_CAP_ABORT_LIM, 16'h0000}))
        else $error("abort limit byte wrong");
    evtreq_lim_a: assert property (rd_p(10'h040, 32'hff00_0000,
        {`CCF_CAP_EVTREQ_LIM, 24'h00_0000}))
        else $error("event request limit byte wrong");
    limits_min_a: assert property (ar_go && s_axi_araddr[11:2] == 10'h040 |=>
        s_axi_rdata[23:16] >= 8'h03 && s_axi_rdata[31:24] >= 8'h03)
        else $error("limit below four outstanding");
    unmapped_rd_a: assert property (ar_go && s_axi_araddr[11:10] == 2'b11 |=>
        s_axi_rvalid && s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0000_0000)
        else $error("unmapped read not refused with zero data");
    rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid ##0 $stable(s_axi_rdata))
        else $error("read answer dropped or changed before taken");

    cover property (|evt_notice);
    cover property ($rose(irq));
    cover property (ar_go && s_axi_araddr[11:10] == 2'b11);
    cover property (s_axi_rvalid && !s_axi_rready);
endmodule : ccf_bank_asserts

bind ccf_bank ccf_bank_asserts ccf_bank_asserts_inst (.clk_sys(clk_sys), .nrst(nrst),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .evt_raise(evt_raise), .evt_notice(evt_notice), .irq(irq));

`default_nettype wire

// file: dv/test_controller_capability_fields.sv
/*
 * test_controller_capability_fields: self-checking bench of ccf_bank.
 * assumes: ccf_defines.svh on the include path; bench drives all ports.
 */
`include "ccf_defines.svh"
`default_nettype none

module test_controller_capability_fields;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000;
    logic [11:0] s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] evt_raise = 2'b00;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [31:0] s_axi_rdata, rd, e;
    logic [1:0] s_axi_bresp, s_axi_rresp, evt_notice, rsp, en, ie, v;
    logic [31:0] seed = 32'h0001_00c9;
    logic slow_rd = 1'b0;
    logic [11:0] caps [3] = '{12'h05c, 12'h060, 12'h100};
    int error_cnt = 0;
    int check_count = 0;
    int i;

    always #2 clk_sys = ~clk_sys;

    ccf_bank ccf_bank_inst (.clk_sys, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .evt_raise, .evt_notice, .irq);

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    function automatic logic [31:0] cap_exp(input logic [11:0] a);
        case (a)
            12'h05c: return {22'h00_0000, `CCF_CAP_FW_ACT, `CCF_CAP_NS_ATTR, 8'h00};
            12'h060: return {31'h0000_0000, `CCF_CAP_HOSTID128};
            default: return {`CCF_CAP_EVTREQ_LIM, `CCF_CAP_ABORT_LIM, 12'h000,
                `CCF_CAP_NS_MGMT, `CCF_CAP_FW, `CCF_CAP_FORMAT, `CCF_CAP_SECURITY};
        endcase
    endfunction : cap_exp

    task close_out;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : close_out

    task chk_word(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_word

    task chk_bits(input logic [1:0] got, input logic [1:0] exp);
        chk_word({30'h0000_0000, got}, {30'h0000_0000, exp});
    endtask : chk_bits

    // handshakes are judged at the falling edge, acted on at the next rising edge
    task axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ta, tw, tb;
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int n = 0; n < 64; n++)
        begin
            @(negedge clk_sys);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tb = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge clk_sys);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (tb)
            begin
                s_axi_bready <= 1'b0;
                return;
            end
        end
        error_cnt++;
        close_out();
    endtask : axi_wr

    task axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta, tr, tv;
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= !slow_rd;
        for (int n = 0; n < 64; n++)
        begin
            @(negedge clk_sys);
            ta = s_axi_arvalid && s_axi_arready;
            tv = s_axi_rvalid;
            tr = s_axi_rvalid && s_axi_rready;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge clk_sys);
            if (ta) s_axi_arvalid <= 1'b0;
            if (tr)
            begin
                s_axi_rready <= 1'b0;
                return;
            end
            // a slow master raises ready only once the answer stands
            if (tv) s_axi_rready <= 1'b1;
        end
        error_cnt++;
        close_out();
    endtask : axi_rd

    initial
    begin
        repeat (16) @(posedge clk_sys);
        nrst <= 1'b1;
        @(negedge clk_sys);
        chk_bits(evt_notice, 2'b00);
        chk_bits({1'b0, irq}, 2'b00);
        chk_bits({s_axi_awready, s_axi_arready}, 2'b11);
        chk_bits({s_axi_bvalid, s_axi_rvalid}, 2'b00);
        // capability words, then a write attempt that must not change them
        for (i = 0; i < 3; i++)
        begin
            e = cap_exp(caps[i]);
            axi_rd(caps[i], rd, rsp);
            chk_word(rd, e);
            axi_wr(caps[i], seed, rsp);
            seed = lfsr(seed);
            chk_bits(rsp, `CCF_RESP_OKAY);
            axi_rd(caps[i], rd, rsp);
            chk_word(rd, e);
        end
        // unmapped addresses are refused and read zero
        for (i = 0; i < 4; i++)
        begin
            slow_rd = i[0];
            axi_rd({2'b11, seed[9:2], 2'b00}, rd, rsp);
            chk_bits(rsp, `CCF_RESP_SLVERR);
            chk_word(rd, `CCF_ZERO32);
            axi_wr({2'b11, seed[19:12], 2'b00}, seed, rsp);
            chk_bits(rsp, `CCF_RESP_SLVERR);
            seed = lfsr(seed);
        end
        // events under random enables; the first pass raises both with none enabled
        for (i = 0; i < 12; i++)
        begin
            en = (i == 0) ? 2'b00 : seed[1:0];
            ie = seed[3:2];
            v = (i == 0) ? 2'b11 : seed[5:4];
            slow_rd = seed[6];
            seed = lfsr(seed);
            axi_wr(`CCF_OFS_IRQ_ENABLE, {30'h0000_0000, ie}, rsp);
            axi_wr(`CCF_OFS_EVT_ENABLE, {30'h0000_0000, en}, rsp);
            axi_rd(`CCF_OFS_EVT_ENABLE, rd, rsp);
            chk_word(rd, {30'h0000_0000, en});
            @(posedge clk_sys);
            evt_raise <= v;
            @(posedge clk_sys);
            evt_raise <= 2'b00;
            @(negedge clk_sys);
            chk_bits(evt_notice, v & en);
            chk_bits({1'b0, irq}, {1'b0, |(v & en & ie)});
            axi_rd(`CCF_OFS_IRQ_STATUS, rd, rsp);
            chk_word(rd, {30'h0000_0000, v & en});
            axi_wr(`CCF_OFS_IRQ_CLEAR, 32'h0000_0003, rsp);
            @(negedge clk_sys);
            chk_bits({1'b0, irq}, 2'b00);
            axi_rd(`CCF_OFS_IRQ_STATUS, rd, rsp);
            chk_word(rd, `CCF_ZERO32);
        end
        // corner: a raise held across the clear keeps the status set
        axi_wr(`CCF_OFS_EVT_ENABLE, 32'h0000_0003, rsp);
        evt_raise <= 2'b11;
        axi_wr(`CCF_OFS_IRQ_CLEAR, 32'h0000_0003, rsp);
        evt_raise <= 2'b00;
        axi_rd(`CCF_OFS_IRQ_STATUS, rd, rsp);
        chk_word(rd, 32'h0000_0003);
        // reset in mid-run wipes enables, status and the interrupt
        @(posedge clk_sys);
        nrst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        nrst <= 1'b1;
        @(negedge clk_sys);
        chk_bits(evt_notice, 2'b00);
        chk_bits({1'b0, irq}, 2'b00);
        axi_rd(`CCF_OFS_EVT_ENABLE, rd, rsp);
        chk_word(rd, `CCF_ZERO32);
        axi_rd(`CCF_OFS_IRQ_STATUS, rd, rsp);
        chk_word(rd, `CCF_ZERO32);
        close_out();
    end
endmodule : test_controller_capability_fields

`default_nettype wire
